// File: hw/pin_status_pkg.sv
// package: register map, field codes and ahb codes for the pin/status block
package pin_status_pkg;
    // register byte addresses (printed offsets are not all multiples of four)
    localparam logic [7:0]  IDX_PINS_LO      = 8'h37;
    localparam logic [7:0]  IDX_PINS_HI      = 8'h38;
    localparam logic [7:0]  IDX_LOCK_CLEAR   = 8'h39;
    localparam logic [7:0]  IDX_STATUS       = 8'h3A;
    localparam logic [7:0]  IDX_OUT_FORMAT   = 8'h3E;
    localparam logic [9:0]  ADDR_PINS_LO     = {IDX_PINS_LO, 2'b00};
    localparam logic [9:0]  ADDR_PINS_HI     = {IDX_PINS_HI, 2'b00};
    localparam logic [9:0]  ADDR_LOCK_CLEAR  = {IDX_LOCK_CLEAR, 2'b00};
    localparam logic [9:0]  ADDR_STATUS      = {IDX_STATUS, 2'b00};
    localparam logic [9:0]  ADDR_OUT_FORMAT  = {IDX_OUT_FORMAT, 2'b00};
    localparam logic [9:0]  ADDR_PIN_INPUTS  = 10'h104;
    localparam int          ADDR_W           = 10;
    // reset values
    localparam logic [7:0]  PINS_RESET       = 8'hFF;
    localparam logic [7:0]  CLEAR_RESET      = 8'h00;
    localparam logic [2:0]  FORMAT_RESET     = 3'h0;
    // field layout
    localparam int          NUM_PINS         = 8;
    localparam int          FIELD_W          = 2;
    localparam int          CLEAR_BIT        = 0;
    localparam int          ST_SOURCE        = 0;
    localparam int          ST_HLOCK         = 1;
    localparam int          ST_VLOCK         = 2;
    localparam int          ST_SCLOCK        = 3;
    localparam int          ST_LOST          = 4;
    localparam int          ST_RATE50        = 5;
    localparam int          ST_LINEALT       = 6;
    localparam int          ST_PEAK          = 7;
    // pin function codes
    localparam logic [1:0]  FN_LOW           = 2'h0;
    localparam logic [1:0]  FN_HIGH          = 2'h1;
    localparam logic [1:0]  FN_RESERVED      = 2'h2;
    localparam logic [1:0]  FN_INPUT         = 2'h3;
    // output format code that frees the pins for general-purpose use
    localparam logic [2:0]  FMT_TEN_BIT      = 3'h3;
    // ahb codes
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [2:0]  HSIZE_WORD       = 3'h2;
endpackage

// File: hw/pin_bus_if.sv
// interface: pin-function settings and pin levels between top and pin driver
`timescale 1ns/1ps
interface pin_bus_if;
    import pin_status_pkg::*;
    logic [2*NUM_PINS-1:0] func;
    logic                  ten_bit_mode;
    logic                  line_tick;
    logic [NUM_PINS-1:0]   pin_level;
    logic [NUM_PINS-1:0]   pin_out;
    logic [NUM_PINS-1:0]   pin_oe;
    logic [NUM_PINS-1:0]   pin_sample;
    modport ctrl (output func, ten_bit_mode, line_tick, pin_level,
                  input pin_out, pin_oe, pin_sample);
    modport drv  (input func, ten_bit_mode, line_tick, pin_level,
                  output pin_out, pin_oe, pin_sample);
endinterface

// File: hw/pin_driver.sv
// module: per-pin output/enable decode and line-rate input sampling
`timescale 1ns/1ps
module pin_driver
    import pin_status_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // settings and pins
    pin_bus_if.drv    pb
);
    logic [NUM_PINS-1:0] out_next;
    logic [NUM_PINS-1:0] oe_next;
    logic [NUM_PINS-1:0] out_reg;
    logic [NUM_PINS-1:0] oe_reg;
    logic [NUM_PINS-1:0] smp_next;
    logic [NUM_PINS-1:0] smp_reg;

    function automatic logic [1:0] field_of(input logic [2*NUM_PINS-1:0] f,
                                             input int i);
        return f[i*FIELD_W +: FIELD_W];
    endfunction

    always_comb begin
        out_next = '0;
        oe_next  = '0;
        smp_next = smp_reg;
        for (int i = 0; i < NUM_PINS; i++) begin
            // pins stay with video data outside 10-bit mode
            if (pb.ten_bit_mode) begin
                unique case (field_of(pb.func, i))
                    FN_LOW: begin
                        oe_next[i] = 1'b1;
                    end
                    FN_HIGH: begin
                        oe_next[i]  = 1'b1;
                        out_next[i] = 1'b1;
                    end
                    // reserved code treated as input: never drives
                    default: begin
                        oe_next[i] = 1'b0;
                    end
                endcase
                if (pb.line_tick &&
                    field_of(pb.func, i) == FN_INPUT) begin
                    smp_next[i] = pb.pin_level[i];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_reg <= '0;
            oe_reg  <= '0;
            smp_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
            smp_reg <= smp_next;
        end
    end

    assign pb.pin_out    = out_reg;
    assign pb.pin_oe     = oe_reg;
    assign pb.pin_sample = smp_reg;

    chk_input_no_drive: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (field_of(pb.func, 0) == FN_INPUT) |=> !pb.pin_oe[0])
        else $error("input pin 0 is driven");
    chk_high_drives_one: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (pb.ten_bit_mode && field_of(pb.func, 0) == FN_HIGH)
        |=> (pb.pin_oe[0] && pb.pin_out[0]))
        else $error("pin 0 not driven high");
    chk_mode_gates_pins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !pb.ten_bit_mode |=> (pb.pin_oe == '0))
        else $error("pin driven outside 10-bit mode");
    cov_pin_low: cover property (
        @(posedge hclk) pb.pin_oe[1] && !pb.pin_out[1]);
endmodule // pin_driver

// File: hw/pin_function_and_lock_status.sv
// module: ahb-lite register bank for aux pin functions and lock status
//
// Summary of operation
// - code 11 is input and reset value, FFh; code 10 reserved
// - writing 1 to bit 0 of 39h clears lost-lock flag
// - writing 0 to 39h bit 0 does nothing; resets 00h; bits 7:1 reserved
// - lost-lock bit 4 is sticky until cleared by software
// - status bit 3 shows colour subcarrier lock
// - status bit 2 shows vertical sync lock
// - status bit 1 shows horizontal sync lock
// - bit 7 peak white detected; bit 0 source kind, 1 for VCR
// - bit 6 line-alternating; bit 5 field rate, 1 for 50 Hz
// - in 10-bit mode only, input pins sampled into read-only bits once per video line
// - 10-bit mode is output format code 011
`timescale 1ns/1ps
module pin_function_and_lock_status
    import pin_status_pkg::*;
(
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // video status from the decoder core, asynchronous
    input  wire logic        peak_white,
    input  wire logic        line_alternating,
    input  wire logic        field_rate_50,
    input  wire logic        lock_lost_event,
    input  wire logic        subcarrier_locked,
    input  wire logic        vsync_locked,
    input  wire logic        hsync_locked,
    input  wire logic        source_kind_flag,
    input  wire logic        line_start,
    // aux pins 2 to 9, three signals per two-way pin
    input  wire logic [7:0]  aux_pin_in,
    output logic      [7:0]  aux_pin_out,
    output logic      [7:0]  aux_pin_oe
);
    // ------------------------------------------------------------------
    // pin and status synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = 17;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic [SYNC_W-1:0] sync_next;
    logic [SYNC_W-1:0] raw;

    assign raw = {aux_pin_in, line_start, peak_white, line_alternating,
                  field_rate_50, lock_lost_event, subcarrier_locked,
                  vsync_locked, hsync_locked, source_kind_flag};
    assign sync_next = meta_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= raw;
            sync_reg <= sync_next;
        end
    end

    logic       s_source;
    logic       s_hlock;
    logic       s_vlock;
    logic       s_sclock;
    logic       s_lost_evt;
    logic       s_rate50;
    logic       s_linealt;
    logic       s_peak;
    logic       s_line;
    logic [7:0] s_pins;
    assign {s_pins, s_line, s_peak, s_linealt, s_rate50, s_lost_evt,
            s_sclock, s_vlock, s_hlock, s_source} = sync_reg;

    // one-cycle line tick from the synchronised line marker
    logic line_d_reg;
    logic line_d_next;
    assign line_d_next = s_line;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_d_reg <= 1'b0;
        end else begin
            line_d_reg <= line_d_next;
        end
    end

    // ------------------------------------------------------------------
    // ahb-lite address phase capture
    // ------------------------------------------------------------------
    logic            wr_pend_reg;
    logic            wr_pend_next;
    logic            rd_pend_reg;
    logic            rd_pend_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic            take;

    // only aligned word transfers are honoured; others become no-ops
    assign take = hsel && hready && htrans == HTRANS_NONSEQ &&
                  hsize == HSIZE_WORD;

    // carrier to the pin driver; the read mux below reads its samples
    pin_bus_if pb ();

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  pins_lo_reg;
    logic [7:0]  pins_lo_next;
    logic [7:0]  pins_hi_reg;
    logic [7:0]  pins_hi_next;
    logic [2:0]  format_reg;
    logic [2:0]  format_next;
    logic        lost_reg;
    logic        lost_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        clear_hit;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    assign clear_hit = wr_pend_reg && hit(addr_reg, ADDR_LOCK_CLEAR) &&
                       hwdata[CLEAR_BIT];

    always_comb begin
        wr_pend_next = take && hwrite;
        rd_pend_next = take && !hwrite;
        addr_next    = take ? haddr[ADDR_W-1:0] : addr_reg;
        pins_lo_next = pins_lo_reg;
        pins_hi_next = pins_hi_reg;
        format_next  = format_reg;
        rdata_next   = '0;
        if (wr_pend_reg) begin
            if (hit(addr_reg, ADDR_PINS_LO)) begin
                pins_lo_next = hwdata[7:0];
            end
            if (hit(addr_reg, ADDR_PINS_HI)) begin
                pins_hi_next = hwdata[7:0];
            end
            if (hit(addr_reg, ADDR_OUT_FORMAT)) begin
                format_next = hwdata[2:0];
            end
        end
        // event set wins over a clear in the same cycle
        lost_next = lost_reg;
        if (clear_hit) begin
            lost_next = 1'b0;
        end
        if (s_lost_evt) begin
            lost_next = 1'b1;
        end
        if (take && !hwrite) begin
            unique case (haddr[ADDR_W-1:0])
                ADDR_PINS_LO:    rdata_next[7:0] = pins_lo_reg;
                ADDR_PINS_HI:    rdata_next[7:0] = pins_hi_reg;
                ADDR_OUT_FORMAT: rdata_next[2:0] = format_reg;
                // command register reads back its reset value
                ADDR_LOCK_CLEAR: rdata_next[7:0] = CLEAR_RESET;
                ADDR_STATUS: begin
                    rdata_next[ST_PEAK]    = s_peak;
                    rdata_next[ST_LINEALT] = s_linealt;
                    rdata_next[ST_RATE50]  = s_rate50;
                    rdata_next[ST_LOST]    = lost_next;
                    rdata_next[ST_SCLOCK]  = s_sclock;
                    rdata_next[ST_VLOCK]   = s_vlock;
                    rdata_next[ST_HLOCK]   = s_hlock;
                    rdata_next[ST_SOURCE]  = s_source;
                end
                ADDR_PIN_INPUTS: rdata_next[7:0] = pb.pin_sample;
                default:         rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= '0;
            pins_lo_reg <= PINS_RESET;
            pins_hi_reg <= PINS_RESET;
            format_reg  <= FORMAT_RESET;
            lost_reg    <= 1'b0;
            rdata_reg   <= '0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg    <= addr_next;
            pins_lo_reg <= pins_lo_next;
            pins_hi_reg <= pins_hi_next;
            format_reg  <= format_next;
            lost_reg    <= lost_next;
            rdata_reg   <= rdata_next;
        end
    end

    // zero-wait slave, always OKAY
    assign hrdata    = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------------
    assign pb.func         = {pins_hi_reg, pins_lo_reg};
    assign pb.ten_bit_mode = format_reg == FMT_TEN_BIT;
    assign pb.line_tick    = s_line && !line_d_reg;
    assign pb.pin_level    = s_pins;

    pin_driver u_pin_driver (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pb      (pb)
    );
    assign aux_pin_out = pb.pin_out;
    assign aux_pin_oe  = pb.pin_oe;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_lost_sticky: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (lost_reg && !clear_hit) |=> lost_reg)
        else $error("lost-lock flag dropped without clear");
    chk_lost_sets: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_lost_evt |=> lost_reg)
        else $error("lost-lock event not caught");
    chk_clear_works: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (clear_hit && !s_lost_evt) |=> !lost_reg)
        else $error("clear did not clear lost-lock flag");
    chk_zero_no_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && hit(addr_reg, ADDR_LOCK_CLEAR) &&
         !hwdata[CLEAR_BIT] && lost_reg) |=> lost_reg)
        else $error("writing zero cleared the flag");
    chk_status_hlock: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[ADDR_W-1:0] == ADDR_STATUS)
        |=> hrdata[ST_HLOCK] == $past(s_hlock))
        else $error("hsync lock bit wrong");
    chk_status_vlock: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[ADDR_W-1:0] == ADDR_STATUS)
        |=> hrdata[ST_VLOCK] == $past(s_vlock))
        else $error("vsync lock bit wrong");
    chk_status_sclock: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[ADDR_W-1:0] == ADDR_STATUS)
        |=> hrdata[ST_SCLOCK] == $past(s_sclock))
        else $error("subcarrier lock bit wrong");
    chk_pin_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && hit(addr_reg, ADDR_PINS_HI))
        |=> pins_hi_reg == $past(hwdata[7:0]))
        else $error("pin function write lost");
    chk_pin_write_lo: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && hit(addr_reg, ADDR_PINS_LO))
        |=> pins_lo_reg == $past(hwdata[7:0]))
        else $error("low pin function write lost");
    chk_status_source: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[ADDR_W-1:0] == ADDR_STATUS)
        |=> (hrdata[ST_PEAK] == $past(s_peak) &&
             hrdata[ST_SOURCE] == $past(s_source)))
        else $error("peak white or source bit wrong");
    chk_status_video: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[ADDR_W-1:0] == ADDR_STATUS)
        |=> (hrdata[ST_LINEALT] == $past(s_linealt) &&
             hrdata[ST_RATE50] == $past(s_rate50)))
        else $error("line-alternating or field rate bit wrong");
    chk_clear_reads_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (rd_pend_reg && hit(addr_reg, ADDR_LOCK_CLEAR)) |-> hrdata == '0)
        else $error("clear register did not read zero");
    chk_lost_readback: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (rd_pend_reg && hit(addr_reg, ADDR_STATUS))
        |-> hrdata[ST_LOST] == lost_reg)
        else $error("lost-lock bit read back wrong");
    chk_pin_inputs_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (rd_pend_reg && hit(addr_reg, ADDR_PIN_INPUTS))
        |-> hrdata[7:0] == $past(pb.pin_sample))
        else $error("pin input samples read back wrong");
    cov_clear: cover property (@(posedge hclk) clear_hit && lost_reg);
    cov_ten_bit: cover property (@(posedge hclk) pb.ten_bit_mode);
    cov_status_read: cover property (@(posedge hclk)
        rd_pend_reg && hit(addr_reg, ADDR_STATUS));
endmodule // pin_function_and_lock_status

// File: verif/board_pin_model.sv
// model: board logic that drives the aux pins the device leaves undriven
`timescale 1ns/1ps
module board_pin_model (
    // device side of each two-way pin
    input  wire logic [7:0] dev_out,
    input  wire logic [7:0] dev_oe,
    // level the board would put on a released pin
    input  wire logic [7:0] board_level,
    // resolved wire level fed back to the device
    output logic      [7:0] pin_level
);
    // ------------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------------
    // the board never fights the device: it only drives pins left released
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = dev_oe[i] ? dev_out[i] : board_level[i];
        end
    end
endmodule // board_pin_model

// File: verif/pin_function_and_lock_status_bench.sv
// testbench: register, pin and status checks for the pin/status block
`timescale 1ns/1ps
module pin_function_and_lock_status_bench;
    import pin_status_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  st_in;
    logic        line_start;
    logic [7:0]  board_level;
    logic [7:0]  aux_pin_in;
    logic [7:0]  aux_pin_out;
    logic [7:0]  aux_pin_oe;
    logic [31:0] v;
    int          miscompares;
    int          n_checks;

    // ------------------------------------------------------------------
    // design and board
    // ------------------------------------------------------------------
    pin_function_and_lock_status pin_function_and_lock_status_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .peak_white(st_in[7]),
        .line_alternating(st_in[6]), .field_rate_50(st_in[5]),
        .lock_lost_event(st_in[4]), .subcarrier_locked(st_in[3]),
        .vsync_locked(st_in[2]), .hsync_locked(st_in[1]),
        .source_kind_flag(st_in[0]), .line_start(line_start),
        .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out),
        .aux_pin_oe(aux_pin_oe));

    board_pin_model board_pin_model_i (
        .dev_out(aux_pin_out), .dev_oe(aux_pin_oe),
        .board_level(board_level), .pin_level(aux_pin_in));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test;
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single word transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [9:0] a,
                        input logic [31:0] d, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h00000000, d);
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values;
        rd(ADDR_PINS_LO, v);
        check(v, 32'h000000FF);
        rd(ADDR_PINS_HI, v);
        check(v, 32'h000000FF);
        rd(ADDR_LOCK_CLEAR, v);
        check(v, 32'h00000000);
        rd(ADDR_STATUS, v);
        check(v, 32'h00000000);
        check({24'h000000, aux_pin_oe}, 32'h00000000);
    endtask

    task automatic t_pin_codes;
        wr(ADDR_OUT_FORMAT, {29'h0, FMT_TEN_BIT});
        repeat (2) @(posedge hclk);
        check({24'h000000, aux_pin_oe}, 32'h00000000);
        // every code at least once: 11 input, 10 reserved, 01 high, 00 low
        wr(ADDR_PINS_LO, 32'h000000E4);
        wr(ADDR_PINS_HI, 32'h0000001B);
        repeat (2) @(posedge hclk);
        check({24'h000000, aux_pin_oe}, 32'h000000C3);
        check({24'h000000, aux_pin_out & aux_pin_oe}, 32'h00000042);
        rd(ADDR_PINS_LO, v);
        check(v, 32'h000000E4);
        rd(ADDR_PINS_HI, v);
        check(v, 32'h0000001B);
        wr(ADDR_PINS_LO, 32'h00000000);
        wr(ADDR_PINS_HI, 32'h00000055);
        repeat (2) @(posedge hclk);
        check({24'h000000, aux_pin_oe}, 32'h000000FF);
        check({24'h000000, aux_pin_out}, 32'h000000F0);
        // any other output format hands the pins back to video data
        for (int f = 0; f < 8; f++) begin
            if (f != 3) begin
                wr(ADDR_OUT_FORMAT, f);
                repeat (2) @(posedge hclk);
                check({24'h000000, aux_pin_oe}, 32'h00000000);
            end
        end
        wr(ADDR_OUT_FORMAT, {29'h0, FMT_TEN_BIT});
        repeat (2) @(posedge hclk);
        check({24'h000000, aux_pin_oe}, 32'h000000FF);
    endtask

    task automatic t_status;
        for (int i = 0; i < 8; i++) begin
            if (i != 4) begin
                st_in <= 8'h01 << i;
                repeat (4) @(posedge hclk);
                rd(ADDR_STATUS, v);
                check(v, 32'h1 << i);
            end
        end
        st_in <= 8'hEF;
        repeat (4) @(posedge hclk);
        rd(ADDR_STATUS, v);
        check(v, 32'h000000EF);
        st_in <= 8'h00;
        repeat (4) @(posedge hclk);
    endtask

    task automatic t_lost_lock;
        st_in <= 8'h10;
        repeat (2) @(posedge hclk);
        st_in <= 8'h00;
        repeat (4) @(posedge hclk);
        rd(ADDR_STATUS, v);
        check(v, 32'h00000010);
        // a zero in the clear bit, reserved bits set, must leave the flag
        wr(ADDR_LOCK_CLEAR, 32'h000000FE);
        @(posedge hclk);
        rd(ADDR_STATUS, v);
        check(v, 32'h00000010);
        wr(ADDR_LOCK_CLEAR, 32'h00000001);
        @(posedge hclk);
        rd(ADDR_STATUS, v);
        check(v, 32'h00000000);
        rd(ADDR_LOCK_CLEAR, v);
        check(v, 32'h00000000);
    endtask

    task automatic line_tick;
        line_start <= 1'b1;
        repeat (3) @(posedge hclk);
        line_start <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic t_line_sample;
        // pins 2..7 inputs, pins 8 and 9 driven low
        wr(ADDR_PINS_LO, 32'h000000FF);
        wr(ADDR_PINS_HI, 32'h0000000F);
        board_level <= 8'h96;
        repeat (4) @(posedge hclk);
        line_tick();
        rd(ADDR_PIN_INPUTS, v);
        check(v & 32'h3F, 32'h00000016);
        board_level <= 8'h69;
        repeat (4) @(posedge hclk);
        rd(ADDR_PIN_INPUTS, v);
        check(v & 32'h3F, 32'h00000016);
        line_tick();
        rd(ADDR_PIN_INPUTS, v);
        check(v & 32'h3F, 32'h00000029);
    endtask

    task automatic t_unmapped;
        rd(10'h200, v);
        check(v, 32'h00000000);
        check({31'h0, hresp}, 32'h00000000);
        wr(ADDR_STATUS, 32'h000000FF);
        rd(ADDR_STATUS, v);
        check(v, 32'h00000000);
        // a byte-wide write is not honoured and leaves the register alone
        hsize <= 3'h0;
        wr(ADDR_PINS_HI, 32'h00000000);
        hsize <= HSIZE_WORD;
        rd(ADDR_PINS_HI, v);
        check(v, 32'h0000000F);
    endtask

    task automatic t_mid_reset;
        wr(ADDR_PINS_LO, 32'h00000055);
        do_reset();
        check({24'h000000, aux_pin_oe}, 32'h00000000);
        rd(ADDR_PINS_LO, v);
        check(v, 32'h000000FF);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h00000000;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hsize       = HSIZE_WORD;
        hwdata      = 32'h00000000;
        st_in       = 8'h00;
        line_start  = 1'b0;
        board_level = 8'hA5;
        miscompares = 0;
        n_checks    = 0;
        do_reset();
        t_reset_values();
        t_pin_codes();
        t_status();
        t_lost_lock();
        t_line_sample();
        t_unmapped();
        t_mid_reset();
        finish_test();
    end

    // the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        finish_test();
    end
endmodule // pin_function_and_lock_status_bench
